// >>> rtl/scb_map.vh
// Register offsets, field positions and reset values of the configuration register bank.
`ifndef SCB_MAP_VH
`define SCB_MAP_VH
// ==========================================================================
// Register byte offsets
`define SCB_OFS_WIN23      6'h04
`define SCB_OFS_WIN4       6'h08
`define SCB_OFS_WIN67      6'h0c
`define SCB_OFS_MISC       6'h10
`define SCB_OFS_DMA_ADDR   6'h14
`define SCB_OFS_RST_CTRL   6'h18
// ==========================================================================
// Chip-select window fields
`define SCB_HI_MATCH       31:24
`define SCB_HI_MASK        23:16
`define SCB_LO_MATCH       15:8
`define SCB_LO_MASK        7:0
// ==========================================================================
// Miscellaneous register fields
`define SCB_F_IRQ_NS       31:28
`define SCB_F_PERIPH_NS    27:26
`define SCB_F_MGR_NS       25
`define SCB_F_BOOT_ADDR    24
`define SCB_F_SPNIDEN      9
`define SCB_F_NIDEN        8
`define SCB_F_SPIDEN       7
`define SCB_F_DBGEN        6
`define SCB_F_REMAP        5:4
`define SCB_F_MEMMAP       1:0
`define SCB_MISC_WMASK     32'hff0003f3
`define SCB_REMAP_CS0      2'h1
`define SCB_REMAP_CS4      2'h2
`define SCB_MEMMAP_AXI     2'h1
`define SCB_MEMMAP_NOEXT   2'h2
// ==========================================================================
// Reset values
`define SCB_RST_WIN        32'h00000000
`define SCB_RST_MISC       32'h000003d0
`define SCB_RST_DMA_ADDR   32'h00000000
`define SCB_RST_RST_CTRL   32'h1fffefff
`define SCB_RST_CTRL_WMASK 32'hdfffefff
`endif

// >>> rtl/scb_win_match.v
// Address window matcher for one chip select using an 8-bit match and mask.
`timescale 1ns/1ps
`default_nettype none
module scb_win_match #(
	parameter W = 8
) (
	input  wire [W-1:0] addr_top_i,
	input  wire [W-1:0] match_i,
	input  wire [W-1:0] mask_i,
	output wire         hit_o
);
	wire [W-1:0] diff;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			// A zero mask bit makes the address bit a don't-care.
			assign diff[g] = mask_i[g] & (addr_top_i[g] ^ match_i[g]);
		end
	endgenerate
	assign hit_o = ~|diff;
endmodule // scb_win_match
`default_nettype wire

// >>> rtl/scb_regbank.v
// Configuration register bank: chip-select windows, misc options, DMA boot address, reset control.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scb_map.vh"
module scb_regbank #(
	parameter AW = 6
) (
	input  wire          clk_i,
	input  wire          rst_i,
	// Wishbone classic slave.
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [AW-1:0] wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	output reg           wb_err_o,
	// Address window decode for the static memory controller.
	input  wire [7:0]    mem_addr_top_i,
	output reg  [2:0]    win_hit_o,
	// DMA engine reset-exit options.
	input  wire          dma_rst_i,
	output reg  [3:0]    dma_irq_nonsecure_o,
	output reg  [1:0]    dma_periph_nonsecure_o,
	output reg           dma_manager_nonsecure_o,
	output reg           dma_boot_from_address_o,
	output reg  [31:0]   dma_start_address_o,
	// Debug authentication.
	output reg           secure_noninvasive_dbg_en_o,
	output reg           noninvasive_dbg_en_o,
	output reg           secure_invasive_dbg_en_o,
	output reg           invasive_dbg_en_o,
	// Memory map control.
	output reg  [1:0]    static_mem_remap_bus_o,
	output reg           remap_valid_o,
	output reg           axi_master_at_zero_o,
	output reg           ext_axi_en_o,
	// Chip reset controls.
	output reg  [31:0]   reset_control_o
);
	// ==========================================================================
	// Register storage
	reg  [31:0] win23_r;
	reg  [15:0] win4_r;
	reg  [31:0] misc_r;
	reg  [31:0] dma_addr_r;
	reg  [31:0] rst_ctrl_r;
	wire [31:0] win4_merged;

	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire [31:0] lane    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        hit_w23 = (wb_adr_i == `SCB_OFS_WIN23);
	wire        hit_w4  = (wb_adr_i == `SCB_OFS_WIN4);
	wire        hit_w67 = (wb_adr_i == `SCB_OFS_WIN67);
	wire        hit_msc = (wb_adr_i == `SCB_OFS_MISC);
	wire        hit_dma = (wb_adr_i == `SCB_OFS_DMA_ADDR);
	wire        hit_rst = (wb_adr_i == `SCB_OFS_RST_CTRL);
	wire        mapped  = hit_w23 | hit_w4 | hit_w67 | hit_msc | hit_dma | hit_rst;
	wire        wr      = req & wb_we_i & mapped;

	// Byte-lane merge of write data into a register value.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [31:0] ln;
		begin
			merge = (old & ~ln) | (nw & ln);
		end
	endfunction

	// ==========================================================================
	// Register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			win23_r    <= `SCB_RST_WIN;
			win4_r     <= 16'h0000;
			misc_r     <= `SCB_RST_MISC;
			dma_addr_r <= `SCB_RST_DMA_ADDR;
			rst_ctrl_r <= `SCB_RST_RST_CTRL;
		end else if (wr) begin
			if (hit_w23)
				win23_r <= merge(win23_r, wb_dat_i, lane);
			// Upper half of the window 4 register holds no storage.
			if (hit_w4)
				win4_r <= win4_merged[15:0];
			if (hit_msc)
				misc_r <= merge(misc_r, wb_dat_i, lane & `SCB_MISC_WMASK);
			if (hit_dma)
				dma_addr_r <= merge(dma_addr_r, wb_dat_i, lane);
			if (hit_rst)
				rst_ctrl_r <= merge(rst_ctrl_r, wb_dat_i, lane & `SCB_RST_CTRL_WMASK);
		end
	end

	assign win4_merged = merge({16'h0000, win4_r}, wb_dat_i, lane);

	// ==========================================================================
	// Bus answer: one-cycle ack, error on unmapped offsets
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
			wb_dat_o <= 32'h00000000;
			if (req & ~wb_we_i) begin
				// The window 6/7 register is reserved and always reads zero.
				if (hit_w23)
					wb_dat_o <= win23_r;
				else if (hit_w4)
					wb_dat_o <= {16'h0000, win4_r};
				else if (hit_msc)
					wb_dat_o <= misc_r;
				else if (hit_dma)
					wb_dat_o <= dma_addr_r;
				else if (hit_rst)
					wb_dat_o <= rst_ctrl_r;
			end
		end
	end

	// ==========================================================================
	// Chip-select window decode
	wire [2:0] hit_w;
	scb_win_match #(.W(8)) u_win2 (
		.addr_top_i (mem_addr_top_i),
		.match_i    (win23_r[`SCB_LO_MATCH]),
		.mask_i     (win23_r[`SCB_LO_MASK]),
		.hit_o      (hit_w[0])
	);
	scb_win_match #(.W(8)) u_win3 (
		.addr_top_i (mem_addr_top_i),
		.match_i    (win23_r[`SCB_HI_MATCH]),
		.mask_i     (win23_r[`SCB_HI_MASK]),
		.hit_o      (hit_w[1])
	);
	scb_win_match #(.W(8)) u_win4 (
		.addr_top_i (mem_addr_top_i),
		.match_i    (win4_r[`SCB_LO_MATCH]),
		.mask_i     (win4_r[`SCB_LO_MASK]),
		.hit_o      (hit_w[2])
	);

	// ==========================================================================
	// Outputs
	// DMA options are latched only while the engine is held in reset, so that a
	// write during operation cannot change its security state under it.
	always @(posedge clk_i) begin
		if (rst_i) begin
			win_hit_o               <= 3'h0;
			dma_irq_nonsecure_o     <= 4'h0;
			dma_periph_nonsecure_o  <= 2'h0;
			dma_manager_nonsecure_o <= 1'b0;
			dma_boot_from_address_o <= 1'b0;
			dma_start_address_o     <= `SCB_RST_DMA_ADDR;
			secure_noninvasive_dbg_en_o <= 1'b1;
			noninvasive_dbg_en_o        <= 1'b1;
			secure_invasive_dbg_en_o    <= 1'b1;
			invasive_dbg_en_o           <= 1'b1;
			static_mem_remap_bus_o  <= `SCB_REMAP_CS0;
			remap_valid_o           <= 1'b1;
			axi_master_at_zero_o    <= 1'b0;
			ext_axi_en_o            <= 1'b1;
			reset_control_o         <= `SCB_RST_RST_CTRL;
		end else begin
			win_hit_o   <= hit_w;
			if (dma_rst_i) begin
				dma_irq_nonsecure_o     <= misc_r[`SCB_F_IRQ_NS];
				dma_periph_nonsecure_o  <= misc_r[`SCB_F_PERIPH_NS];
				dma_manager_nonsecure_o <= misc_r[`SCB_F_MGR_NS];
				dma_boot_from_address_o <= misc_r[`SCB_F_BOOT_ADDR];
				dma_start_address_o     <= dma_addr_r;
			end
			secure_noninvasive_dbg_en_o <= misc_r[`SCB_F_SPNIDEN];
			noninvasive_dbg_en_o        <= misc_r[`SCB_F_NIDEN];
			secure_invasive_dbg_en_o    <= misc_r[`SCB_F_SPIDEN];
			invasive_dbg_en_o           <= misc_r[`SCB_F_DBGEN];
			static_mem_remap_bus_o      <= misc_r[`SCB_F_REMAP];
			// Remap only means something while the memory controller sits at zero.
			remap_valid_o        <= ~misc_r[0] & ((misc_r[`SCB_F_REMAP] == `SCB_REMAP_CS0) |
				(misc_r[`SCB_F_REMAP] == `SCB_REMAP_CS4));
			axi_master_at_zero_o <= (misc_r[`SCB_F_MEMMAP] == `SCB_MEMMAP_AXI);
			ext_axi_en_o         <= (misc_r[`SCB_F_MEMMAP] != `SCB_MEMMAP_NOEXT) &
				(misc_r[`SCB_F_MEMMAP] != `SCB_MEMMAP_AXI);
			reset_control_o      <= rst_ctrl_r;
		end
	end
endmodule // scb_regbank
`default_nettype wire

// >>> verification/scb_regbank_monitor.sv
// Concurrent checks on the ports of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module scb_regbank_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        dma_rst_i,
	input wire logic [3:0]  dma_irq_nonsecure_o,
	input wire logic [31:0] dma_start_address_o,
	input wire logic        invasive_dbg_en_o,
	input wire logic [1:0]  static_mem_remap_bus_o,
	input wire logic        remap_valid_o,
	input wire logic        axi_master_at_zero_o,
	input wire logic        ext_axi_en_o
);
	// ========================================
	// Handshake and output relations
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
	a_take: assert property (p_take) else $error("request not answered");
	property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o; endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_once: assert property (p_once) else $error("ack longer than one cycle");
	property p_err; wb_err_o |-> !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("ack and err together");
	property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dat: assert property (p_dat) else $error("read data outside ack");
	// The past reset term keeps a mid-run reset from looking like a change.
	property p_freeze; !dma_rst_i && !$past(dma_rst_i) && !$past(rst_i) |-> $stable(dma_irq_nonsecure_o) && $stable(dma_start_address_o); endproperty
	a_freeze: assert property (p_freeze) else $error("dma option moved after release");
	property p_rst; $fell(rst_i) |-> invasive_dbg_en_o && static_mem_remap_bus_o == 2'h1 && dma_irq_nonsecure_o == 4'h0; endproperty
	a_rst: assert property (p_rst) else $error("wrong output reset value");
	property p_axi; axi_master_at_zero_o |-> !ext_axi_en_o && !remap_valid_o; endproperty
	a_axi: assert property (p_axi) else $error("memory map decode mismatch");
endmodule // scb_regbank_monitor
bind scb_regbank scb_regbank_monitor i_scb_regbank_monitor (.*);
`default_nettype wire

// >>> verification/scb_regbank_tb.sv
// Self-checking testbench of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "scb_map.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module scb_regbank_tb;
	logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, dma_rst_i = 1;
	logic [5:0]  wb_adr_i = 0, ofs[6];
	logic [3:0]  wb_sel_i = 0;
	logic [7:0]  mem_addr_top_i = 0, a, mt[3], mk[3];
	logic [31:0] wb_dat_i = 0, v, m[6], msk[6];
	logic [33:0] e, q[$];
	logic [2:0]  h;
	wire  [31:0] wb_dat_o, dma_start_address_o, reset_control_o;
	wire  [3:0]  dma_irq_nonsecure_o;
	wire  [2:0]  win_hit_o;
	wire  [1:0]  dma_periph_nonsecure_o, static_mem_remap_bus_o;
	wire         wb_ack_o, wb_err_o, dma_manager_nonsecure_o, dma_boot_from_address_o, remap_valid_o;
	wire         secure_noninvasive_dbg_en_o, noninvasive_dbg_en_o, secure_invasive_dbg_en_o, invasive_dbg_en_o;
	wire         axi_master_at_zero_o, ext_axi_en_o;
	int          err_count = 0, cmp_count = 0, ticks = 0;
	scb_regbank i_scb_regbank (.*);
	// ========================================
	// Clock, watchdog and result checker
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 3000) begin
			err_count++;
			close_out();
		end
	end
	// Each note holds a data-check flag, the expected error bit and the read data.
	always @(posedge clk_i) if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
		e = q.pop_front();
		`CHK("bus_err", e[32], wb_err_o)
		if (e[33]) `CHK("rd_data", e[31:0], wb_dat_o)
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic endtest(input string s);
		$display("test %s done", s);
	endtask
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [33:0] x);
		@(posedge clk_i);
		q.push_back(x);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, ad, d, s};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, 4'hf, 34'h0);
	endtask
	task automatic rd(input logic [5:0] ad, input logic [31:0] d);
		bus(1'b0, ad, 32'h0, 4'hf, {2'b10, d});
	endtask
	// ========================================
	// Test sequence
	initial begin
		void'($urandom(32'hc8c2));
		ofs = '{`SCB_OFS_WIN23, `SCB_OFS_WIN4, `SCB_OFS_WIN67, `SCB_OFS_MISC, `SCB_OFS_DMA_ADDR, `SCB_OFS_RST_CTRL};
		msk = '{32'hffffffff, 32'h0000ffff, 32'h0, `SCB_MISC_WMASK, 32'hffffffff, `SCB_RST_CTRL_WMASK};
		m = '{`SCB_RST_WIN, `SCB_RST_WIN, `SCB_RST_WIN, `SCB_RST_MISC, `SCB_RST_DMA_ADDR, `SCB_RST_RST_CTRL};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (i == 2) continue;
			rd(ofs[i], m[i]);
			v = $urandom();
			v = v & msk[i];
			if (i == 3) v[5:4] = v[4] ? 2'h1 : 2'h2;
			wr(ofs[i], v);
			m[i] = v;
			rd(ofs[i], m[i]);
		end
		#1 `CHK("rst_ctrl", m[5], reset_control_o)
		bus(1'b1, `SCB_OFS_WIN23, 32'h5a5a5a5a, 4'h2, 34'h0);
		rd(`SCB_OFS_WIN23, {m[0][31:16], 8'h5a, m[0][7:0]});
		bus(1'b1, 6'h00, v, 4'hf, {2'b01, 32'h0});
		bus(1'b0, 6'h1c, v, 4'hf, {2'b01, 32'h0});
		endtest("registers");
		for (int k = 0; k < 3; k++) begin
			wr(`SCB_OFS_MISC, {22'h0, 4'(k * 5), (k == 2) ? 2'h2 : 2'h1, 2'h0, 2'(k)});
			@(posedge clk_i);
			#1 `CHK("map_out", {4'(k * 5), (k == 2) ? 2'h2 : 2'h1, k != 1, k == 1, k == 0}, {secure_noninvasive_dbg_en_o, noninvasive_dbg_en_o, secure_invasive_dbg_en_o, invasive_dbg_en_o, static_mem_remap_bus_o, remap_valid_o, axi_master_at_zero_o, ext_axi_en_o})
		end
		endtest("misc");
		v = $urandom();
		wr(`SCB_OFS_MISC, {v[31:24], 24'h000010});
		wr(`SCB_OFS_DMA_ADDR, ~v);
		@(posedge clk_i) dma_rst_i <= 1'b0;
		#1 `CHK("dma_opt", {v[31:24], ~v}, {dma_irq_nonsecure_o, dma_periph_nonsecure_o, dma_manager_nonsecure_o, dma_boot_from_address_o, dma_start_address_o})
		wr(`SCB_OFS_MISC, {~v[31:24], 24'h000010});
		wr(`SCB_OFS_DMA_ADDR, v);
		@(posedge clk_i);
		#1 `CHK("dma_frz", {v[31:24], ~v}, {dma_irq_nonsecure_o, dma_periph_nonsecure_o, dma_manager_nonsecure_o, dma_boot_from_address_o, dma_start_address_o})
		endtest("dma");
		v = $urandom();
		m[1] = v ^ 32'h00a5a5a5;
		wr(`SCB_OFS_WIN23, v);
		wr(`SCB_OFS_WIN4, m[1]);
		mt = '{v[15:8], v[31:24], m[1][15:8]};
		mk = '{v[7:0], v[23:16], m[1][7:0]};
		for (int j = 0; j < 40; j++) begin
			a = $urandom();
			if (j % 2) a = mt[j % 3] ^ (a & ~mk[j % 3]);
			@(posedge clk_i) mem_addr_top_i <= a;
			@(posedge clk_i);
			#1 for (int b = 0; b < 3; b++) h[b] = ((a ^ mt[b]) & mk[b]) == 8'h0;
			`CHK("win_hit", h, win_hit_o)
		end
		endtest("windows");
		close_out();
	end
endmodule // scb_regbank_tb
`default_nettype wire
